// ---- pwtr_avmm_slv.sv ----
// ==========================================
// avalon-mm slave, one wait state per access
module pwtr_avmm_slv #(
	parameter int DATA_W = pwtr_pkg::DATA_W
) (
	// clock and control
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// avalon-mm
	input wire logic [pwtr_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [DATA_W-1:0] avs_writedata_i,
	input wire logic [pwtr_pkg::BE_W-1:0] avs_byteenable_i,
	output logic avs_waitrequest_o,
	output logic [DATA_W-1:0] avs_readdata_o,
	// register side
	pwtr_reg_if.slv bus
);
	if (DATA_W != pwtr_pkg::DATA_W) begin : g_chk
		$error("pwtr_avmm_slv: only 32-bit data is served");
	end

	typedef struct packed {
		logic waitreq;
		logic [DATA_W-1:0] rdata;
	} pwtr_slv_st_t;

	pwtr_slv_st_t st_reg;
	pwtr_slv_st_t st_next;
	logic req;

	// a single wait state keeps read data registered without a combinational path to the bus
	always_comb begin
		st_next = st_reg;
		req = (avs_read_i || avs_write_i) && st_reg.waitreq && ce_i;
		bus.addr = avs_address_i;
		bus.wdata = avs_writedata_i;
		bus.wr_stb = req && avs_write_i && avs_byteenable_i[pwtr_pkg::BE_LANE0];
		if (req) begin
			st_next.waitreq = 1'b0;
			if (avs_read_i) begin
				st_next.rdata = bus.rdata;
			end
		end else begin
			st_next.waitreq = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			st_reg <= '{waitreq: 1'b1, rdata: pwtr_pkg::RD_ZERO};
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	assign avs_waitrequest_o = st_reg.waitreq;
	assign avs_readdata_o = st_reg.rdata;
endmodule

// ---- pwtr_evt_regs.sv ----
// ==========================================
// event flags, interrupt enables, interrupt request
module pwtr_evt_regs #(
	parameter int N_EVT = pwtr_pkg::EVT_N
) (
	// clock and control
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// hardware events, one-cycle pulses
	input wire logic [N_EVT-1:0] set_i,
	// register side
	pwtr_reg_if.core bus,
	// state
	output logic [N_EVT-1:0] flags_o,
	output logic [N_EVT-1:0] enable_o,
	output logic irq_o
);
	if (N_EVT != pwtr_pkg::EVT_N) begin : g_chk
		$error("pwtr_evt_regs: event count fixed by the register map");
	end

	typedef struct packed {
		logic [N_EVT-1:0] flag;
		logic [N_EVT-1:0] en;
		logic irq;
	} pwtr_evt_st_t;

	pwtr_evt_st_t st_reg;
	pwtr_evt_st_t st_next;
	logic [N_EVT-1:0] sel;

	always_comb begin
		st_next = st_reg;
		sel = pwtr_pkg::pwtr_evt_sel(bus.addr);
		for (int i = 0; i < N_EVT; i++) begin
			if (bus.wr_stb && sel[i]) begin
				st_next.flag[i] = bus.wdata[pwtr_pkg::FLAG_BIT];
			end
			// hardware set wins over a software clear in the same cycle
			if (set_i[i]) begin
				st_next.flag[i] = 1'b1;
			end
		end
		if (bus.wr_stb && bus.addr == pwtr_pkg::OFS_INT_EN_SET) begin
			st_next.en = st_reg.en | bus.wdata[N_EVT-1:0];
		end
		if (bus.wr_stb && bus.addr == pwtr_pkg::OFS_INT_EN_CLR) begin
			st_next.en = st_reg.en & ~bus.wdata[N_EVT-1:0];
		end
		st_next.irq = |(st_next.flag & st_next.en);
		bus.rdata = pwtr_pkg::RD_ZERO;
		if (|sel) begin
			bus.rdata[pwtr_pkg::FLAG_BIT] = |(sel & st_reg.flag);
		end else if (pwtr_pkg::pwtr_en_sel(bus.addr)) begin
			bus.rdata[N_EVT-1:0] = st_reg.en;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			st_reg <= '0;
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	assign flags_o = st_reg.flag;
	assign enable_o = st_reg.en;
	assign irq_o = st_reg.irq;
endmodule

// ---- pwtr_pkg.sv ----
// Operation
// - writing 1 to task_constant_latency bit 0 selects constant-latency mode; write-only, resets 0
// - writing 1 to task_low_power bit 0 selects low-power variable-latency mode; write-only
// - cpu entering sleep sets event_cpu_sleep_entry bit 0
// - cpu leaving sleep sets event_cpu_sleep_wake bit 0; reads 0/1, software writable
// - power-fail warning sets event_power_fail_warning bit 0; readable, writable, interrupt source
// - writing 1 to interrupt_enable_set bits 0..2 enables matching event interrupt
// - writing 1 to interrupt_enable_clear bits 0..2 disables matching event interrupt
// - both enable registers read back the shared enable state
package pwtr_pkg;

	// ==========================================
	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;

	// ==========================================
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_TASK_CONST_LAT = 12'h078;
	localparam logic [ADDR_W-1:0] OFS_TASK_LOW_POWER = 12'h07c;
	localparam logic [ADDR_W-1:0] OFS_EVT_POWER_FAIL = 12'h108;
	localparam logic [ADDR_W-1:0] OFS_EVT_SLEEP_ENTRY = 12'h114;
	localparam logic [ADDR_W-1:0] OFS_EVT_SLEEP_WAKE = 12'h118;
	localparam logic [ADDR_W-1:0] OFS_INT_EN_SET = 12'h304;
	localparam logic [ADDR_W-1:0] OFS_INT_EN_CLR = 12'h308;

	// ==========================================
	// fields and reset values
	localparam int TASK_BIT = 0;
	localparam int FLAG_BIT = 0;
	localparam int BE_LANE0 = 0;
	localparam int EVT_PFW = 0;
	localparam int EVT_ENTRY = 1;
	localparam int EVT_WAKE = 2;
	localparam int EVT_N = 3;
	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

	// ==========================================
	// operating mode
	typedef enum logic [1:0] {
		PWTR_MODE_LOW_POWER = 2'b01,
		PWTR_MODE_CONST_LAT = 2'b10
	} pwtr_mode_t;

	localparam pwtr_mode_t MODE_RESET = PWTR_MODE_LOW_POWER;

	// ==========================================
	// decoding
	function automatic logic [EVT_N-1:0] pwtr_evt_sel(input logic [ADDR_W-1:0] a);
		logic [EVT_N-1:0] s;
		s = '0;
		s[EVT_PFW] = (a == OFS_EVT_POWER_FAIL);
		s[EVT_ENTRY] = (a == OFS_EVT_SLEEP_ENTRY);
		s[EVT_WAKE] = (a == OFS_EVT_SLEEP_WAKE);
		return s;
	endfunction

	function automatic logic pwtr_en_sel(input logic [ADDR_W-1:0] a);
		return (a == OFS_INT_EN_SET) || (a == OFS_INT_EN_CLR);
	endfunction

endpackage

// ---- pwtr_power_task_event.sv ----
// ==========================================
// power control task and event register slice
//
// Chosen here: the Avalon-MM interface to the registers.
module pwtr_power_task_event (
	// clock and control
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// avalon-mm slave
	input wire logic [pwtr_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [pwtr_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [pwtr_pkg::BE_W-1:0] avs_byteenable_i,
	output logic avs_waitrequest_o,
	output logic [pwtr_pkg::DATA_W-1:0] avs_readdata_o,
	// status from the power unit and cpu
	input wire logic cpu_sleeping_i,
	input wire logic power_fail_warning_i,
	// mode, events, interrupt
	output logic [1:0] mode_o,
	output logic [pwtr_pkg::EVT_N-1:0] event_flags_o,
	output logic [pwtr_pkg::EVT_N-1:0] int_enable_o,
	output logic irq_o
);
	// ==========================================
	// state
	typedef struct packed {
		pwtr_pkg::pwtr_mode_t mode;
		logic sleep_prev;
		logic pfw_prev;
	} pwtr_top_st_t;

	pwtr_top_st_t st_reg;
	pwtr_top_st_t st_next;
	logic [pwtr_pkg::EVT_N-1:0] evt_set;

	pwtr_reg_if bus ();

	pwtr_avmm_slv #(
		.DATA_W(pwtr_pkg::DATA_W)
	) u_slv (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_waitrequest_o(avs_waitrequest_o),
		.avs_readdata_o(avs_readdata_o),
		.bus(bus.slv)
	);

	pwtr_evt_regs #(
		.N_EVT(pwtr_pkg::EVT_N)
	) u_evt (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.set_i(evt_set),
		.bus(bus.core),
		.flags_o(event_flags_o),
		.enable_o(int_enable_o),
		.irq_o(irq_o)
	);

	// ==========================================
	// tasks and event edges
	// edges come from held levels, so a level that persists never re-raises a cleared flag
	always_comb begin
		st_next = st_reg;
		st_next.sleep_prev = cpu_sleeping_i;
		st_next.pfw_prev = power_fail_warning_i;
		evt_set = '0;
		evt_set[pwtr_pkg::EVT_PFW] = power_fail_warning_i && !st_reg.pfw_prev;
		evt_set[pwtr_pkg::EVT_ENTRY] = cpu_sleeping_i && !st_reg.sleep_prev;
		evt_set[pwtr_pkg::EVT_WAKE] = !cpu_sleeping_i && st_reg.sleep_prev;
		if (bus.wr_stb && bus.wdata[pwtr_pkg::TASK_BIT]) begin
			if (bus.addr == pwtr_pkg::OFS_TASK_CONST_LAT) begin
				st_next.mode = pwtr_pkg::PWTR_MODE_CONST_LAT;
			end else if (bus.addr == pwtr_pkg::OFS_TASK_LOW_POWER) begin
				st_next.mode = pwtr_pkg::PWTR_MODE_LOW_POWER;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			st_reg <= '{mode: pwtr_pkg::MODE_RESET, sleep_prev: 1'b0, pfw_prev: 1'b0};
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	assign mode_o = st_reg.mode;

	// ==========================================
	// checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i);

	sequence s_wr(logic [pwtr_pkg::ADDR_W-1:0] a);
		bus.wr_stb && bus.addr == a;
	endsequence

	sequence s_rd_en;
		ce_i && avs_read_i && avs_waitrequest_o && avs_address_i == pwtr_pkg::OFS_INT_EN_SET;
	endsequence

	property p_const_lat;
		s_wr(pwtr_pkg::OFS_TASK_CONST_LAT) and bus.wdata[pwtr_pkg::TASK_BIT] |=>
			mode_o == pwtr_pkg::PWTR_MODE_CONST_LAT;
	endproperty
	a_const_lat: assert property (p_const_lat) else $error("constant-latency task ignored");

	property p_low_power;
		s_wr(pwtr_pkg::OFS_TASK_LOW_POWER) and bus.wdata[pwtr_pkg::TASK_BIT] |=>
			mode_o == pwtr_pkg::PWTR_MODE_LOW_POWER;
	endproperty
	a_low_power: assert property (p_low_power) else $error("low-power task ignored");

	property p_entry;
		ce_i && cpu_sleeping_i && !st_reg.sleep_prev |=> event_flags_o[pwtr_pkg::EVT_ENTRY];
	endproperty
	a_entry: assert property (p_entry) else $error("sleep entry flag not set");

	property p_wake;
		ce_i && !cpu_sleeping_i && st_reg.sleep_prev |=> event_flags_o[pwtr_pkg::EVT_WAKE];
	endproperty
	a_wake: assert property (p_wake) else $error("sleep wake flag not set");

	property p_pfw;
		ce_i && power_fail_warning_i && !st_reg.pfw_prev |=> event_flags_o[pwtr_pkg::EVT_PFW];
	endproperty
	a_pfw: assert property (p_pfw) else $error("power fail flag not set");

	property p_en_set;
		s_wr(pwtr_pkg::OFS_INT_EN_SET) |=>
			int_enable_o == ($past(int_enable_o) | $past(bus.wdata[pwtr_pkg::EVT_N-1:0]));
	endproperty
	a_en_set: assert property (p_en_set) else $error("enable set wrong");

	property p_en_clr;
		s_wr(pwtr_pkg::OFS_INT_EN_CLR) |=>
			int_enable_o == ($past(int_enable_o) & ~$past(bus.wdata[pwtr_pkg::EVT_N-1:0]));
	endproperty
	a_en_clr: assert property (p_en_clr) else $error("enable clear wrong");

	property p_rd_en;
		s_rd_en |=> !avs_waitrequest_o && avs_readdata_o[pwtr_pkg::EVT_N-1:0] == $past(int_enable_o);
	endproperty
	a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");

	property p_irq;
		irq_o == |(event_flags_o & int_enable_o);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt does not follow flags");

	property p_wait_ack;
		ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
	endproperty
	a_wait_ack: assert property (p_wait_ack) else $error("waitrequest timing wrong");

	// ==========================================
	// register contents and read paths
	sequence s_rd(logic [pwtr_pkg::ADDR_W-1:0] a);
		ce_i && avs_read_i && avs_waitrequest_o && avs_address_i == a;
	endsequence

	sequence s_quiet(int i, logic [pwtr_pkg::ADDR_W-1:0] a);
		!evt_set[i] && !(bus.wr_stb && bus.addr == a);
	endsequence

	sequence s_wr_flag(int i, logic [pwtr_pkg::ADDR_W-1:0] a);
		bus.wr_stb && bus.addr == a && !evt_set[i];
	endsequence

	sequence s_wr_zero(logic [pwtr_pkg::ADDR_W-1:0] a);
		bus.wr_stb && bus.addr == a && bus.wdata[pwtr_pkg::EVT_N-1:0] == '0;
	endsequence

	// the default disable would hide reset itself, so this one opts out
	property p_reset_state;
		disable iff (1'b0) srst_i |=> avs_waitrequest_o && avs_readdata_o == pwtr_pkg::RD_ZERO &&
			mode_o == pwtr_pkg::MODE_RESET && event_flags_o == '0 && int_enable_o == '0 && !irq_o;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

	property p_mode_onehot;
		$onehot(mode_o);
	endproperty
	a_mode_onehot: assert property (p_mode_onehot) else $error("mode not one-hot");

	property p_mode_hold;
		!(bus.wr_stb && bus.wdata[pwtr_pkg::TASK_BIT]) |=> $stable(mode_o);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed without a task");

	property p_const_idle;
		s_wr(pwtr_pkg::OFS_TASK_CONST_LAT) and !bus.wdata[pwtr_pkg::TASK_BIT] |=> $stable(mode_o);
	endproperty
	a_const_idle: assert property (p_const_idle) else $error("constant-latency task fired on zero");

	property p_low_idle;
		s_wr(pwtr_pkg::OFS_TASK_LOW_POWER) and !bus.wdata[pwtr_pkg::TASK_BIT] |=> $stable(mode_o);
	endproperty
	a_low_idle: assert property (p_low_idle) else $error("low-power task fired on zero");

	// flags move only on a hardware edge or a software write
	property p_pfw_hold;
		s_quiet(pwtr_pkg::EVT_PFW, pwtr_pkg::OFS_EVT_POWER_FAIL) |=> $stable(event_flags_o[pwtr_pkg::EVT_PFW]);
	endproperty
	a_pfw_hold: assert property (p_pfw_hold) else $error("power fail flag moved by itself");

	property p_entry_hold;
		s_quiet(pwtr_pkg::EVT_ENTRY, pwtr_pkg::OFS_EVT_SLEEP_ENTRY) |=> $stable(event_flags_o[pwtr_pkg::EVT_ENTRY]);
	endproperty
	a_entry_hold: assert property (p_entry_hold) else $error("sleep entry flag moved by itself");

	property p_wake_hold;
		s_quiet(pwtr_pkg::EVT_WAKE, pwtr_pkg::OFS_EVT_SLEEP_WAKE) |=> $stable(event_flags_o[pwtr_pkg::EVT_WAKE]);
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("sleep wake flag moved by itself");

	property p_pfw_sw;
		s_wr_flag(pwtr_pkg::EVT_PFW, pwtr_pkg::OFS_EVT_POWER_FAIL) |=>
			event_flags_o[pwtr_pkg::EVT_PFW] == $past(bus.wdata[pwtr_pkg::FLAG_BIT]);
	endproperty
	a_pfw_sw: assert property (p_pfw_sw) else $error("power fail flag write lost");

	property p_entry_sw;
		s_wr_flag(pwtr_pkg::EVT_ENTRY, pwtr_pkg::OFS_EVT_SLEEP_ENTRY) |=>
			event_flags_o[pwtr_pkg::EVT_ENTRY] == $past(bus.wdata[pwtr_pkg::FLAG_BIT]);
	endproperty
	a_entry_sw: assert property (p_entry_sw) else $error("sleep entry flag write lost");

	property p_wake_sw;
		s_wr_flag(pwtr_pkg::EVT_WAKE, pwtr_pkg::OFS_EVT_SLEEP_WAKE) |=>
			event_flags_o[pwtr_pkg::EVT_WAKE] == $past(bus.wdata[pwtr_pkg::FLAG_BIT]);
	endproperty
	a_wake_sw: assert property (p_wake_sw) else $error("sleep wake flag write lost");

	// event reads carry the flag alone; upper bits stay zero
	property p_rd_pfw;
		s_rd(pwtr_pkg::OFS_EVT_POWER_FAIL) |=>
			avs_readdata_o == {{(pwtr_pkg::DATA_W-1){1'b0}}, $past(event_flags_o[pwtr_pkg::EVT_PFW])};
	endproperty
	a_rd_pfw: assert property (p_rd_pfw) else $error("power fail flag read wrong");

	property p_rd_entry;
		s_rd(pwtr_pkg::OFS_EVT_SLEEP_ENTRY) |=>
			avs_readdata_o == {{(pwtr_pkg::DATA_W-1){1'b0}}, $past(event_flags_o[pwtr_pkg::EVT_ENTRY])};
	endproperty
	a_rd_entry: assert property (p_rd_entry) else $error("sleep entry flag read wrong");

	property p_rd_wake;
		s_rd(pwtr_pkg::OFS_EVT_SLEEP_WAKE) |=>
			avs_readdata_o == {{(pwtr_pkg::DATA_W-1){1'b0}}, $past(event_flags_o[pwtr_pkg::EVT_WAKE])};
	endproperty
	a_rd_wake: assert property (p_rd_wake) else $error("sleep wake flag read wrong");

	property p_rd_const;
		s_rd(pwtr_pkg::OFS_TASK_CONST_LAT) |=> avs_readdata_o == pwtr_pkg::RD_ZERO;
	endproperty
	a_rd_const: assert property (p_rd_const) else $error("constant-latency task readable");

	property p_rd_low;
		s_rd(pwtr_pkg::OFS_TASK_LOW_POWER) |=> avs_readdata_o == pwtr_pkg::RD_ZERO;
	endproperty
	a_rd_low: assert property (p_rd_low) else $error("low-power task readable");

	property p_rd_en_clr;
		s_rd(pwtr_pkg::OFS_INT_EN_CLR) |=>
			avs_readdata_o == {{(pwtr_pkg::DATA_W-pwtr_pkg::EVT_N){1'b0}}, $past(int_enable_o)};
	endproperty
	a_rd_en_clr: assert property (p_rd_en_clr) else $error("enable read through clear wrong");

	// ==========================================
	// enables and bus handshake
	property p_en_hold;
		!(bus.wr_stb && pwtr_pkg::pwtr_en_sel(bus.addr)) |=> $stable(int_enable_o);
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("enables moved without a write");

	property p_en_set_zero;
		s_wr_zero(pwtr_pkg::OFS_INT_EN_SET) |=> $stable(int_enable_o);
	endproperty
	a_en_set_zero: assert property (p_en_set_zero) else $error("zero set write changed enables");

	property p_en_clr_zero;
		s_wr_zero(pwtr_pkg::OFS_INT_EN_CLR) |=> $stable(int_enable_o);
	endproperty
	a_en_clr_zero: assert property (p_en_clr_zero) else $error("zero clear write changed enables");

	// lane 0 holds every used bit, so a write without it is acked but dropped
	property p_be_ignored;
		ce_i && avs_write_i && avs_waitrequest_o && !avs_byteenable_i[pwtr_pkg::BE_LANE0] |=>
			$stable(int_enable_o) && $stable(mode_o);
	endproperty
	a_be_ignored: assert property (p_be_ignored) else $error("write without lane 0 took effect");

	property p_wait_idle;
		avs_waitrequest_o && !(ce_i && (avs_read_i || avs_write_i)) |=> avs_waitrequest_o;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("waitrequest dropped with no request");

	property p_rdata_hold;
		!(ce_i && avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");
endmodule

// ---- pwtr_power_task_event_bench.sv ----
module pwtr_power_task_event_bench;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================
	// signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic sleeping = 1'b0;
	logic pfw = 1'b0;
	logic [pwtr_pkg::ADDR_W-1:0] addr = '0;
	logic [pwtr_pkg::DATA_W-1:0] wdata = '0;
	logic [pwtr_pkg::BE_W-1:0] be = 4'hf;
	logic [pwtr_pkg::DATA_W-1:0] rdata;
	logic waitreq;
	logic irq;
	logic [1:0] mode;
	logic [2:0] flags;
	logic [2:0] en;
	logic [2:0] m_en = 3'h0;
	logic [2:0] m_flags = 3'h0;
	logic [31:0] q;
	logic [31:0] d;
	int n_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	// task, task, event x3, enable set/clear, unmapped
	localparam logic [11:0] OFS [8] = '{pwtr_pkg::OFS_TASK_CONST_LAT, pwtr_pkg::OFS_TASK_LOW_POWER,
		pwtr_pkg::OFS_EVT_POWER_FAIL, pwtr_pkg::OFS_EVT_SLEEP_ENTRY, pwtr_pkg::OFS_EVT_SLEEP_WAKE,
		pwtr_pkg::OFS_INT_EN_SET, pwtr_pkg::OFS_INT_EN_CLR, 12'h400};

	pwtr_power_task_event uut (
		.ref_clk_i(clk),
		.srst_i(rst),
		.ce_i(ce),
		.avs_address_i(addr),
		.avs_read_i(rd),
		.avs_write_i(wr),
		.avs_writedata_i(wdata),
		.avs_byteenable_i(be),
		.avs_waitrequest_o(waitreq),
		.avs_readdata_o(rdata),
		.cpu_sleeping_i(sleeping),
		.power_fail_warning_i(pfw),
		.mode_o(mode),
		.event_flags_o(flags),
		.int_enable_o(en),
		.irq_o(irq)
	);

	initial begin
		forever #5 clk = ~clk;
	end

	// ==========================================
	// helpers
	task automatic wrap_up();
		if (n_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// request held until waitrequest is seen low; no fixed latency assumed
	task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] dat, output logic [31:0] res);
		@(posedge clk);
		addr <= a;
		wr <= we;
		rd <= !we;
		wdata <= dat;
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		res = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	function automatic logic [31:0] exp_irq();
		return {31'h0, |(m_flags & m_en)};
	endfunction

	task automatic check_state();
		repeat (2) @(posedge clk);
		chk("event flags", {29'h0, flags}, {29'h0, m_flags});
		chk("irq", {31'h0, irq}, exp_irq());
		chk("enables", {29'h0, en}, {29'h0, m_en});
	endtask

	// ==========================================
	// timeout
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			wrap_up();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		void'($urandom(32'h5535));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			bus(1'b0, OFS[k], 32'h0, q);
			chk("reset read", q, 32'h0);
		end
		chk("mode after reset", {30'h0, mode}, 32'h1);
		// tasks: bit 0 clear must not trigger
		bus(1'b1, OFS[0], $urandom & 32'hffff_fffe, q);
		chk("mode idle write", {30'h0, mode}, 32'h1);
		bus(1'b1, OFS[0], $urandom | 32'h1, q);
		chk("mode const", {30'h0, mode}, 32'h2);
		bus(1'b0, OFS[0], 32'h0, q);
		chk("task readback", q, 32'h0);
		bus(1'b1, OFS[1], $urandom & 32'hffff_fffe, q);
		chk("mode idle write", {30'h0, mode}, 32'h2);
		bus(1'b1, OFS[1], $urandom | 32'h1, q);
		chk("mode low power", {30'h0, mode}, 32'h1);
		// random enable set and clear, read through either register
		for (int i = 0; i < 16; i++) begin
			d = $urandom;
			bus(1'b1, OFS[d[31] ? 5 : 6], d, q);
			m_en = d[31] ? (m_en | d[2:0]) : (m_en & ~d[2:0]);
			bus(1'b0, OFS[d[30] ? 5 : 6], 32'h0, q);
			chk("enable readback", q, {29'h0, m_en});
		end
		bus(1'b1, OFS[6], 32'h7, q);
		bus(1'b1, OFS[5], 32'h5, q);
		bus(1'b1, OFS[5], 32'h0, q);
		bus(1'b1, OFS[6], 32'h0, q);
		m_en = 3'h5;
		check_state();
		// hardware events; entry is masked so irq gating is visible
		pfw <= 1'b1;
		m_flags[0] = 1'b1;
		check_state();
		sleeping <= 1'b1;
		m_flags[1] = 1'b1;
		check_state();
		sleeping <= 1'b0;
		m_flags[2] = 1'b1;
		check_state();
		pfw <= 1'b0;
		check_state();
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, OFS[2+i], 32'h0, q);
			chk("event read", q, {31'h0, m_flags[i]});
		end
		// software clears each flag; irq must follow
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, OFS[2+i], $urandom & 32'hffff_fffe, q);
			m_flags[i] = 1'b0;
			check_state();
		end
		// clock enable low freezes edge history; the held edge lands once it returns
		ce <= 1'b0;
		sleeping <= 1'b1;
		check_state();
		ce <= 1'b1;
		m_flags[1] = 1'b1;
		check_state();
		sleeping <= 1'b0;
		m_flags[2] = 1'b1;
		check_state();
		bus(1'b1, OFS[3], 32'h0, q);
		m_flags[1] = 1'b0;
		check_state();
		bus(1'b1, OFS[4], 32'h1, q);
		m_flags[2] = 1'b1;
		check_state();
		bus(1'b1, OFS[6], 32'h4, q);
		m_en = 3'h1;
		check_state();
		// write with byte lane 0 off is acknowledged but ignored
		be <= 4'he;
		bus(1'b1, OFS[5], 32'h6, q);
		be <= 4'hf;
		check_state();
		bus(1'b1, OFS[7], 32'hffff_ffff, q);
		bus(1'b0, OFS[7], 32'h0, q);
		chk("unmapped read", q, 32'h0);
		wrap_up();
	end
endmodule

// ---- pwtr_reg_if.sv ----
// ==========================================
// register access between bus slave and register logic
interface pwtr_reg_if;
	logic wr_stb;
	logic [pwtr_pkg::ADDR_W-1:0] addr;
	logic [pwtr_pkg::DATA_W-1:0] wdata;
	logic [pwtr_pkg::DATA_W-1:0] rdata;

	modport slv(output wr_stb, output addr, output wdata, input rdata);
	modport core(input wr_stb, input addr, input wdata, output rdata);
endinterface
